// *** gst_tracker.sv ***
`timescale 1ns/1ps
// What this block does
// - remote flag set on remote-enable plus own listen address
// - remote clears on enable drop, go-to-local when listener, local call without lockout
// - in-charge set by interface clear as system controller or control pass
// - in-charge clears on foreign interface clear or passing control away
// - attention flag follows the attention line level
// - talker flag set on own talk address plus enabled secondary
// - talker clears on untalk, other talk address, own listen, ifc
// - listener flag set on own listen address or shadow handshake standby
// - listener clears on unlisten, own talk, ifc, plain standby
// - go-offline clears remote, in-charge, talker and listener flags
// - trigger flag set on trigger while listener, cleared at next message
// - clear flag set on device clear or selected clear, cleared next message
// - error cause held as gpib code beside the status word
// - code zero when the last call had no fault
// - code one when in-charge call made without being in charge
// - code two on write with no listener or unaccepted command
// - code three on read or write while unaddressed and not in charge
// - code three on shadow standby while attention already released
// - code four on invalid argument, zero timeout included
// - bad interface clear duration and controller address 31 are invalid
// - an invalid argument aborts the whole function
// - code five on ifc or sre without system controller; capable at reset
// - error flag set after failed call, cleared after good call
// - lockout set on local lockout, cleared on enable drop or go-offline
module gst_tracker
  import gst_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RESETN,
  input  wire logic        I_CYC,
  input  wire logic        I_STB,
  input  wire logic        I_WE,
  input  wire logic [7:0]  I_ADR,
  input  wire logic [3:0]  I_SEL,
  input  wire logic [31:0] I_DAT,
  input  wire logic        I_ATN,
  input  wire logic        I_REN,
  input  wire logic        I_IFC,
  input  wire logic        I_DAV,
  input  wire logic [7:0]  I_DIO,
  input  wire logic        I_CMD_ACCEPTED,
  input  wire logic        I_LISTENER_PRESENT,
  output logic      [31:0] O_DAT,
  output logic             O_ACK
);

  // ----------------------------------------------------------------------
  // bus sampling
  // ----------------------------------------------------------------------
  gst_bus_t bus_q;
  gst_bus_t bus_d;
  logic     dav_prev_q;

  always_comb begin
    bus_d.atn = I_ATN;
    bus_d.ren = I_REN;
    bus_d.ifc = I_IFC;
    bus_d.dav = I_DAV;
    bus_d.dio = I_DIO;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      bus_q      <= '0;
      dav_prev_q <= 1'b0;
    end else begin
      bus_q      <= bus_d;
      dav_prev_q <= bus_q.dav;
    end
  end

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic        lockout_flag_q;
  logic        far_controlled_flag_q;
  logic        controller_in_charge_flag_q;
  logic        talker_addressed_flag_q;
  logic        listener_addressed_flag_q;
  logic        trigger_seen_flag_q;
  logic        clear_seen_flag_q;
  logic        err_q;
  logic [7:0]  code_q;
  logic [4:0]  my_addr_q;
  logic [4:0]  my_sec_q;
  logic        sec_en_q;
  logic        sys_ctrl_q;
  logic [15:0] arg_q;
  logic        sec_pend_q;
  logic        sec_is_talk_q;

  // ----------------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------------
  logic      req;
  logic      wr;
  gst_func_t fn;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign req = I_CYC & I_STB & ~O_ACK;
  assign wr  = req & I_WE;
  assign fn  = (wr && hit(I_ADR, FUNC_OFS) && I_SEL[0]) ?
               gst_func_t'(I_DAT[3:0]) : FN_NONE;

  // ----------------------------------------------------------------------
  // command decode on each new byte under attention
  // ----------------------------------------------------------------------
  logic       cmd_stb;
  logic [6:0] c;
  logic       own_la;
  logic       own_ta;
  logic       other_ta;
  logic       sec_ok;
  logic       sec_byte;

  assign cmd_stb  = bus_q.atn & bus_q.dav & ~dav_prev_q;
  assign c        = bus_q.dio[6:0];
  assign sec_byte = cmd_stb && c[6:5] == GRP_SECOND;
  assign sec_ok   = sec_byte && sec_pend_q && c[4:0] == my_sec_q;
  assign own_la   = cmd_stb && c[6:5] == GRP_LISTEN && c[4:0] == my_addr_q
                    && c != CMD_UNL;
  assign own_ta   = cmd_stb && c[6:5] == GRP_TALK && c[4:0] == my_addr_q
                    && c != CMD_UNT;
  assign other_ta = cmd_stb && c[6:5] == GRP_TALK && c[4:0] != my_addr_q
                    && c != CMD_UNT;

  logic la_done;
  logic ta_done;
  assign la_done = sec_en_q ? (sec_ok & ~sec_is_talk_q) : own_la;
  assign ta_done = sec_en_q ? (sec_ok & sec_is_talk_q) : own_ta;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sec_pend_q    <= 1'b0;
      sec_is_talk_q <= 1'b0;
    end else if (cmd_stb) begin
      sec_pend_q    <= own_la | own_ta;
      sec_is_talk_q <= own_ta;
    end
  end

  // ----------------------------------------------------------------------
  // function outcome
  // ----------------------------------------------------------------------
  logic       call;
  logic       fail;
  logic [7:0] code_d;
  logic       bad_arg;

  assign call = fn != FN_NONE && fn != FN_NEWMSG;

  always_comb begin
    bad_arg = 1'b0;
    if (fn == FN_TMO)
      bad_arg = arg_q == 16'h0000;
    if (fn == FN_IFC)
      bad_arg = arg_q == 16'h0000;
    if (fn == FN_CADDR)
      bad_arg = arg_q[4:0] == BAD_CTRL_ADDR || arg_q[15:5] != '0;
    if (fn == FN_BADARG)
      bad_arg = 1'b1;
  end

  always_comb begin
    code_d = NO_BUS_FAULT_CODE;
    if (bad_arg)
      code_d = BAD_ARGUMENT_CODE;
    else if ((fn == FN_IFC || fn == FN_SRE) && !sys_ctrl_q)
      code_d = NO_SYSTEM_CTRL_CODE;
    else if ((fn == FN_PCT || fn == FN_CMD || fn == FN_GTS ||
              fn == FN_GTS_SH) && !controller_in_charge_flag_q)
      code_d = NOT_IN_CHARGE_CODE;
    else if (fn == FN_GTS_SH && !bus_q.atn)
      code_d = NOT_ADDRESSED_CODE;
    else if ((fn == FN_RD && !listener_addressed_flag_q ||
              fn == FN_WRT && !talker_addressed_flag_q) &&
             !controller_in_charge_flag_q)
      code_d = NOT_ADDRESSED_CODE;
    else if (fn == FN_WRT && !I_LISTENER_PRESENT ||
             fn == FN_CMD && !I_CMD_ACCEPTED)
      code_d = NO_LISTENER_CODE;
  end

  assign fail = code_d != NO_BUS_FAULT_CODE;

  // functions take effect only when the call succeeds
  logic ok;
  assign ok = call & ~fail;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      err_q  <= 1'b0;
      code_q <= NO_BUS_FAULT_CODE;
    end else if (call) begin
      err_q  <= fail;
      code_q <= code_d;
    end
  end

  // ----------------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      my_addr_q  <= PRIMARY_ADDR_RST;
      my_sec_q   <= PRIMARY_ADDR_RST;
      sec_en_q   <= 1'b0;
      sys_ctrl_q <= 1'b1;
    end else begin
      if (wr && hit(I_ADR, CONFIG_OFS) && I_SEL[1]) begin
        my_addr_q <= I_DAT[12:8];
        sec_en_q  <= I_DAT[15];
      end
      if (wr && hit(I_ADR, CONFIG_OFS) && I_SEL[2])
        my_sec_q <= I_DAT[20:16];
      if (wr && hit(I_ADR, CONFIG_OFS) && I_SEL[0])
        sys_ctrl_q <= I_DAT[0];
      if (ok && fn == FN_RSC)
        sys_ctrl_q <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN)
      arg_q <= '0;
    else if (wr && hit(I_ADR, ARG_OFS))
      arg_q <= I_DAT[15:0];
  end

  // ----------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------
  logic onl;
  assign onl = ok && fn == FN_ONL;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN)
      lockout_flag_q <= 1'b0;
    else if (!bus_q.ren || onl)
      lockout_flag_q <= 1'b0;
    else if (cmd_stb && c == CMD_LLO)
      lockout_flag_q <= 1'b1;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN)
      far_controlled_flag_q <= 1'b0;
    else if (!bus_q.ren || onl)
      far_controlled_flag_q <= 1'b0;
    else if (la_done)
      far_controlled_flag_q <= 1'b1;
    else if (cmd_stb && c == CMD_GTL && listener_addressed_flag_q)
      far_controlled_flag_q <= 1'b0;
    else if (ok && fn == FN_LOC && !lockout_flag_q)
      far_controlled_flag_q <= 1'b0;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN)
      controller_in_charge_flag_q <= 1'b0;
    else if (onl)
      controller_in_charge_flag_q <= 1'b0;
    else if (ok && fn == FN_IFC)
      controller_in_charge_flag_q <= 1'b1;
    else if (bus_q.ifc || ok && fn == FN_PCT)
      controller_in_charge_flag_q <= 1'b0;
    else if (cmd_stb && c == CMD_TCT && talker_addressed_flag_q)
      controller_in_charge_flag_q <= 1'b1;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN)
      talker_addressed_flag_q <= 1'b0;
    else if (onl || bus_q.ifc)
      talker_addressed_flag_q <= 1'b0;
    else if (ta_done)
      talker_addressed_flag_q <= 1'b1;
    else if (cmd_stb && (c == CMD_UNT || other_ta || own_la))
      talker_addressed_flag_q <= 1'b0;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN)
      listener_addressed_flag_q <= 1'b0;
    else if (onl || bus_q.ifc)
      listener_addressed_flag_q <= 1'b0;
    else if (la_done || ok && fn == FN_GTS_SH)
      listener_addressed_flag_q <= 1'b1;
    else if (cmd_stb && (c == CMD_UNL || own_ta) || ok && fn == FN_GTS)
      listener_addressed_flag_q <= 1'b0;
  end

  // event flags: a bus event in the same cycle as a new message wins
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN)
      trigger_seen_flag_q <= 1'b0;
    else if (cmd_stb && c == CMD_GET && listener_addressed_flag_q)
      trigger_seen_flag_q <= 1'b1;
    else if (fn == FN_NEWMSG)
      trigger_seen_flag_q <= 1'b0;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN)
      clear_seen_flag_q <= 1'b0;
    else if (cmd_stb && (c == CMD_DCL ||
             c == CMD_SDC && listener_addressed_flag_q))
      clear_seen_flag_q <= 1'b1;
    else if (fn == FN_NEWMSG)
      clear_seen_flag_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // read back and acknowledge
  // ----------------------------------------------------------------------
  logic [31:0] rd_d;

  always_comb begin
    rd_d = '0;
    if (hit(I_ADR, STATUS_OFS)) begin
      rd_d[ERR_BIT]  = err_q;
      rd_d[CMPL_BIT] = 1'b1;
      rd_d[LOCKOUT_BIT] = lockout_flag_q;
      rd_d[FAR_CTRL_BIT] = far_controlled_flag_q;
      rd_d[IN_CHARGE_BIT] = controller_in_charge_flag_q;
      rd_d[ATN_BIT]  = bus_q.atn;
      rd_d[TAL_BIT]  = talker_addressed_flag_q;
      rd_d[LIS_BIT]  = listener_addressed_flag_q;
      rd_d[TRG_BIT]  = trigger_seen_flag_q;
      rd_d[CLR_BIT]  = clear_seen_flag_q;
    end else if (hit(I_ADR, ERROR_OFS))
      rd_d[7:0] = code_q;
    else if (hit(I_ADR, CONFIG_OFS))
      rd_d = {11'h000, my_sec_q, sec_en_q, 2'h0, my_addr_q,
              7'h00, sys_ctrl_q};
    else if (hit(I_ADR, ARG_OFS))
      rd_d[15:0] = arg_q;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_ACK <= 1'b0;
      O_DAT <= '0;
    end else begin
      O_ACK <= req;
      O_DAT <= (req && !I_WE) ? rd_d : '0;
    end
  end

endmodule

// *** gst_pkg.sv ***
package gst_pkg;

  // ----------------------------------------------------------------------
  // register map, word addresses as byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS  = 8'h00;
  localparam logic [7:0] ERROR_OFS   = 8'h04;
  localparam logic [7:0] FUNC_OFS    = 8'h08;
  localparam logic [7:0] CONFIG_OFS  = 8'h0c;
  localparam logic [7:0] ARG_OFS     = 8'h10;

  // ----------------------------------------------------------------------
  // status word bit positions
  // ----------------------------------------------------------------------
  localparam int ERR_BIT       = 15;
  localparam int CMPL_BIT      = 8;
  localparam int LOCKOUT_BIT   = 7;
  localparam int FAR_CTRL_BIT  = 6;
  localparam int IN_CHARGE_BIT = 5;
  localparam int ATN_BIT       = 4;
  localparam int TAL_BIT       = 3;
  localparam int LIS_BIT       = 2;
  localparam int TRG_BIT       = 1;
  localparam int CLR_BIT       = 0;

  // ----------------------------------------------------------------------
  // gpib error codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] NO_BUS_FAULT_CODE   = 8'h00;
  localparam logic [7:0] NOT_IN_CHARGE_CODE  = 8'h01;
  localparam logic [7:0] NO_LISTENER_CODE    = 8'h02;
  localparam logic [7:0] NOT_ADDRESSED_CODE  = 8'h03;
  localparam logic [7:0] BAD_ARGUMENT_CODE   = 8'h04;
  localparam logic [7:0] NO_SYSTEM_CTRL_CODE = 8'h05;

  // ----------------------------------------------------------------------
  // bus commands (low 7 bits of a byte sent with attention)
  // ----------------------------------------------------------------------
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_TCT = 7'h09;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK   = 2'h2;
  localparam logic [1:0] GRP_SECOND = 2'h3;

  // reset address and invalid controller address
  localparam logic [4:0] PRIMARY_ADDR_RST = 5'h00;
  localparam logic [4:0] BAD_CTRL_ADDR    = 5'h1f;

  // ----------------------------------------------------------------------
  // host functions
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    FN_NONE    = 4'h0,
    FN_IFC     = 4'h1,
    FN_SRE     = 4'h2,
    FN_LOC     = 4'h3,
    FN_ONL     = 4'h4,
    FN_GTS     = 4'h5,
    FN_GTS_SH  = 4'h6,
    FN_PCT     = 4'h7,
    FN_WRT     = 4'h8,
    FN_RD      = 4'h9,
    FN_CMD     = 4'ha,
    FN_TMO     = 4'hb,
    FN_CADDR   = 4'hc,
    FN_RSC     = 4'hd,
    FN_BADARG  = 4'he,
    FN_NEWMSG  = 4'hf
  } gst_func_t;

  // sampled bus lines
  typedef struct packed {
    logic       atn;
    logic       ren;
    logic       ifc;
    logic       dav;
    logic [7:0] dio;
  } gst_bus_t;

endpackage

// *** gst_tracker_props.sv ***
`timescale 1ns/1ps
module gst_tracker_props
  import gst_pkg::*;
(
  input wire logic        I_CLK,
  input wire logic        I_RESETN,
  input wire logic        I_CYC,
  input wire logic        I_STB,
  input wire logic        I_WE,
  input wire logic [7:0]  I_ADR,
  input wire logic [31:0] I_DAT,
  input wire logic        I_ATN,
  input wire logic        I_REN,
  input wire logic        I_DAV,
  input wire logic [31:0] O_DAT,
  input wire logic        O_ACK
);
  // ----------------------------------------------------------------
  // request and line history
  // ----------------------------------------------------------------
  logic [7:0] adr_q;
  logic       we_q;
  logic [3:0] fn_q;
  logic       quiet_q;
  logic [3:0] atn_q;
  logic [3:0] ren_q;
  logic       take;
  logic       rd_st;
  logic       rd_er;
  assign take  = I_CYC && I_STB && !O_ACK;
  assign rd_st = O_ACK && !we_q && adr_q == STATUS_OFS;
  assign rd_er = O_ACK && !we_q && adr_q == ERROR_OFS;
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      adr_q <= 8'h00;
      we_q  <= 1'b0;
    end else if (take) begin
      adr_q <= I_ADR;
      we_q  <= I_WE;
    end
  end
  // last host function and whether no bus command arrived since
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      fn_q    <= 4'h0;
      quiet_q <= 1'b0;
    end else if (take && I_WE && I_ADR == FUNC_OFS) begin
      fn_q    <= I_DAT[3:0];
      quiet_q <= !I_DAV;
    end else begin
      quiet_q <= quiet_q && !I_DAV;
    end
  end
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      atn_q <= 4'h0;
      ren_q <= 4'h0;
    end else begin
      atn_q <= {atn_q[2:0], I_ATN};
      ren_q <= {ren_q[2:0], I_REN};
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  ack_one_cycle_a: assert property (O_ACK |=> !O_ACK)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (take |=> O_ACK)
    else $error("request not answered");
  data_idle_a: assert property (!O_ACK |-> O_DAT == 32'h0)
    else $error("read data outside ack");
  unmapped_zero_a: assert property
    (O_ACK && !we_q && adr_q > ARG_OFS |-> O_DAT == 32'h0)
    else $error("unmapped read not zero");
  atn_follow_a: assert property
    (rd_st && (&atn_q || atn_q == 4'h0) |-> O_DAT[ATN_BIT] == atn_q[0])
    else $error("attention flag off line level");
  ren_local_a: assert property
    (rd_st && ren_q == 4'h0 |-> !O_DAT[FAR_CTRL_BIT])
    else $error("remote flag without enable");
  badarg_flag_a: assert property
    (rd_st && fn_q == FN_BADARG |-> O_DAT[ERR_BIT])
    else $error("error flag missing");
  badarg_code_a: assert property
    (rd_er && fn_q == FN_BADARG |-> O_DAT[7:0] == BAD_ARGUMENT_CODE)
    else $error("bad argument code missing");
  offline_flags_a: assert property
    (rd_st && fn_q == FN_ONL && quiet_q |-> (O_DAT & 32'h80ec) == 32'h0)
    else $error("flags left after offline");
  offline_code_a: assert property
    (rd_er && fn_q == FN_ONL |-> O_DAT[7:0] == NO_BUS_FAULT_CODE)
    else $error("fault code after offline");
endmodule
bind gst_tracker gst_tracker_props u_props (
  .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_CYC(I_CYC), .I_STB(I_STB),
  .I_WE(I_WE), .I_ADR(I_ADR), .I_DAT(I_DAT), .I_ATN(I_ATN),
  .I_REN(I_REN), .I_DAV(I_DAV), .O_DAT(O_DAT), .O_ACK(O_ACK)
);

// *** gst_far_bus.sv ***
`timescale 1ns/1ps
module gst_far_bus
  import gst_pkg::*;
(
  input  wire logic i_clk,
  output gst_bus_t  o_bus
);
  // ----------------------------------------------------------------
  // other controller, lines asserted high, idle pulled to zero
  // ----------------------------------------------------------------
  initial o_bus = '0;
  task automatic lines(input logic atn, input logic ren);
    @(posedge i_clk);
    o_bus.atn <= atn;
    o_bus.ren <= ren;
  endtask
  // one command byte, data released after the valid pulse
  task automatic send(input logic [7:0] b);
    @(posedge i_clk);
    o_bus.atn <= 1'b1;
    o_bus.dio <= b;
    @(posedge i_clk);
    o_bus.dav <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_bus.dav <= 1'b0;
    @(posedge i_clk);
    o_bus.dio <= 8'h00;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic clear_pulse();
    @(posedge i_clk);
    o_bus.ifc <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_bus.ifc <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb
  import gst_pkg::*;
;
  logic        clk, rstn, cyc, stb, we, acc, lp, ack, in_chg, sysc;
  logic [3:0]  sel;
  logic [4:0]  me;
  logic [7:0]  adr;
  logic [31:0] dat, rd_dat, rdv;
  gst_bus_t    bus;
  int          fail_count, check_count;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  gst_tracker dut (
    .I_CLK(clk), .I_RESETN(rstn), .I_CYC(cyc), .I_STB(stb), .I_WE(we),
    .I_ADR(adr), .I_SEL(sel), .I_DAT(dat), .I_ATN(bus.atn),
    .I_REN(bus.ren), .I_IFC(bus.ifc), .I_DAV(bus.dav), .I_DIO(bus.dio),
    .I_CMD_ACCEPTED(acc), .I_LISTENER_PRESENT(lp), .O_DAT(rd_dat),
    .O_ACK(ack)
  );
  gst_far_bus far (.i_clk(clk), .o_bus(bus));
  // ----------------------------------------------------------------
  // bus cycles, compares and expectations
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rdv = rd_dat;
    if (ack !== 1'b1) fail_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rs(input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(rdv & m, e);
  endtask
  task automatic cfg(input logic sc);
    sysc = sc;
    wb(1'b1, CONFIG_OFS, {16'h0, 3'h0, me, 7'h0, sc});
  endtask
  function automatic logic [7:0] exp_err(input logic [3:0] f,
                                          input logic [15:0] a);
    if (f == FN_BADARG || (f == FN_TMO || f == FN_IFC) && a == 16'h0 ||
        f == FN_CADDR && a >= 16'h1f) return BAD_ARGUMENT_CODE;
    if ((f == FN_IFC || f == FN_SRE) && !sysc) return NO_SYSTEM_CTRL_CODE;
    if ((f == FN_PCT || f == FN_CMD || f == FN_GTS || f == FN_GTS_SH) &&
        !in_chg) return NOT_IN_CHARGE_CODE;
    if ((f == FN_RD || f == FN_WRT) && !in_chg ||
        f == FN_GTS_SH && !bus.atn)
      return NOT_ADDRESSED_CODE;
    if (f == FN_WRT && !lp || f == FN_CMD && !acc) return NO_LISTENER_CODE;
    return NO_BUS_FAULT_CODE;
  endfunction
  task automatic step(input logic [3:0] f, input logic [15:0] a);
    logic [7:0] e;
    @(posedge clk);
    lp  <= 1'($urandom);
    acc <= 1'($urandom);
    wb(1'b1, ARG_OFS, {16'h0, a});
    e = exp_err(f, a);
    wb(1'b1, FUNC_OFS, {28'h0, f});
    wb(1'b0, ERROR_OFS, 32'h0);
    chk(rdv & 32'hff, {24'h0, e});
    rs(32'h8000, (e != 8'h0) ? 32'h8000 : 32'h0);
    if (e == 8'h0 && f == FN_IFC) in_chg = 1'b1;
    if (e == 8'h0 && f == FN_PCT || f == FN_ONL) in_chg = 1'b0;
    if (e == 8'h0 && f == FN_RSC) sysc = 1'b1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {rstn, cyc, stb, we, acc, lp, sel, adr, dat} = '0;
    fail_count = 0;
    check_count = 0;
    in_chg = 1'b0;
    sysc = 1'b1;
    me = 5'h0;
    void'($urandom(14));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rs(32'hffff, 32'h0100);
    wb(1'b0, ERROR_OFS, 32'h0);
    chk(rdv, 32'h0);
    wb(1'b1, 8'h20, $urandom);
    wb(1'b0, 8'h20, 32'h0);
    chk(rdv, 32'h0);
    $display("done reset");
    step(FN_ONL, 16'h0);
    step(FN_PCT, 16'h0);
    step(FN_RD, 16'h0);
    step(FN_TMO, 16'h0);
    step(FN_TMO, 16'(1 + $urandom % 3600));
    step(FN_CADDR, 16'h1f);
    step(FN_CADDR, 16'($urandom % 31));
    step(FN_IFC, 16'h0);
    rs(32'h20, 32'h0);
    step(FN_IFC, 16'h5);
    rs(32'h20, 32'h20);
    step(FN_GTS_SH, 16'h0);
    step(FN_WRT, 16'h0);
    step(FN_CMD, 16'h0);
    step(FN_PCT, 16'h0);
    rs(32'h20, 32'h0);
    step(FN_BADARG, 16'h0);
    cfg(1'b0);
    step(FN_SRE, 16'h0);
    step(FN_IFC, 16'h5);
    step(FN_RSC, 16'h0);
    step(FN_IFC, 16'h5);
    step(FN_ONL, 16'h0);
    rs(32'h20, 32'h0);
    $display("done functions");
    me = 5'(1 + $urandom % 29);
    cfg(1'b1);
    far.lines(1'b1, 1'b1);
    far.send({3'h1, me});
    rs(32'h44, 32'h44);
    far.send({1'b0, CMD_GET});
    rs(32'h2, 32'h2);
    far.send({1'b0, CMD_LLO});
    rs(32'h80, 32'h80);
    far.send({1'b0, CMD_DCL});
    rs(32'h1, 32'h1);
    wb(1'b1, FUNC_OFS, {28'h0, FN_NEWMSG});
    rs(32'h3, 32'h0);
    far.send({3'h2, me});
    rs(32'hc, 32'h8);
    far.send({3'h2, me + 5'h1});
    rs(32'h8, 32'h0);
    far.send({3'h2, me});
    far.send({3'h1, me});
    rs(32'hc, 32'h4);
    far.send({1'b0, CMD_SDC});
    rs(32'h1, 32'h1);
    far.send({1'b0, CMD_UNL});
    rs(32'h4, 32'h0);
    far.send({3'h1, me});
    far.send({1'b0, CMD_GTL});
    rs(32'h40, 32'h0);
    far.send({3'h1, me});
    step(FN_LOC, 16'h0);
    rs(32'h40, 32'h40);
    far.lines(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    rs(32'hc0, 32'h0);
    far.send({3'h2, me});
    far.send({1'b0, CMD_TCT});
    rs(32'h20, 32'h20);
    in_chg = 1'b1;
    step(FN_GTS_SH, 16'h0);
    rs(32'h4, 32'h4);
    step(FN_GTS, 16'h0);
    rs(32'h4, 32'h0);
    far.clear_pulse();
    in_chg = 1'b0;
    rs(32'h28, 32'h0);
    $display("done addressing");
    repeat (6) begin
      far.lines(1'($urandom), 1'b0);
      repeat (4) @(posedge clk);
      rs(32'h10, {27'h0, bus.atn, 4'h0});
    end
    $display("done attention");
    far.lines(1'b1, 1'b1);
    wb(1'b1, CONFIG_OFS, {11'h0, ~me, 1'b1, 2'h0, me, 8'h01});
    far.send({3'h1, me});
    rs(32'h44, 32'h0);
    far.send({3'h3, ~me});
    rs(32'h44, 32'h44);
    cfg(1'b1);
    step(FN_LOC, 16'h0);
    rs(32'h40, 32'h0);
    far.send({3'h1, me});
    far.send({1'b0, CMD_LLO});
    step(FN_ONL, 16'h0);
    rs(32'h80ec, 32'h0);
    $display("done offline");
    close_out();
  end
endmodule
